// ===== rtl/flash_ctl_pkg.sv
// Purpose: constants and carriers for the flash command/protection host controller
// Assumes: 250 MHz system clock, word-mode flash with 19 address bits
// Notes: timing figures are held in ns, cycle counts are derived from them
package flash_ctl_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // strobe low time held well above the glitch filter width
  localparam int GLITCH_NS = 5;
  localparam int STROBE_NS = 40;
  localparam int SETUP_NS = 12;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] STROBE_CNT = 5'(STROBE_CYC);
  localparam logic [4:0] SETUP_CNT = 5'(SETUP_CYC);
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  // command sequence words
  localparam logic [18:0] UNLOCK_ADDR1 = 19'h00555;
  localparam logic [18:0] UNLOCK_ADDR2 = 19'h002AA;
  localparam logic [15:0] UNLOCK_DATA1 = 16'h00AA;
  localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [15:0] ID_CMD_DATA = 16'h0090;
  localparam logic [15:0] RESET_CMD_DATA = 16'h00F0;
  // identification read offsets in word mode
  localparam logic [18:0] ID_MAKER_OFS = 19'h00000;
  localparam logic [18:0] ID_DEVICE_OFS = 19'h00001;
  localparam logic [18:0] ID_PROT_OFS = 19'h00002;
  localparam int SECTOR_LSB = 12;
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_RESET_CMD = 3'h2,
    OP_ID_ENTER = 3'h3,
    OP_ID_READ_HV = 3'h4,
    OP_UNPROTECT = 3'h5
  } op_type;
  typedef struct packed {
    op_type op;
    logic [18:0] addr;
    logic [15:0] data;
  } req_type;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } strobe_type;
endpackage

// ===== rtl/flash_host_ctl.sv
// Purpose: host-side bus controller that drives a parallel NOR flash
// Assumes: single 250 MHz clock; elevated voltages requested by level outputs
// Notes: one request at a time; ready_out low while busy
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module flash_host_ctl (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire flash_ctl_pkg::req_type req_in,
  input wire logic req_valid_in,
  output logic ready_out,
  output logic [15:0] rdata_out,
  output logic rdata_valid_out,
  output logic [18:0] flash_addr_out,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [15:0] flash_dq_in,
  output flash_ctl_pkg::strobe_type strobe_out,
  output logic addr_nine_hv_out,
  output logic reset_pin_hv_out,
  output logic timeout_seen_out,
  input wire logic supply_ok_in
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_SETUP = 6'b000010,
    ST_STROBE = 6'b000100,
    ST_HOLD = 6'b001000,
    ST_NEXT = 6'b010000,
    ST_DONE = 6'b100000
  } state_type;
  //////////////////////////////////////////////////////////////////////////////
  state_type state;
  state_type next_state;
  flash_ctl_pkg::req_type cur;
  logic [1:0] step;
  logic [4:0] cnt;
  logic [15:0] dq_meta;
  logic [15:0] dq_sync;
  logic sup_meta;
  logic sup_sync;
  wire is_read = (cur.op == flash_ctl_pkg::OP_READ) || (cur.op == flash_ctl_pkg::OP_ID_READ_HV);
  wire is_id_enter = cur.op == flash_ctl_pkg::OP_ID_ENTER;
  wire last_step = !is_id_enter || (step == 2'h2);
  // three cycle entry sequence, unlock words first
  wire [18:0] seq_addr = (step == 2'h0) ? flash_ctl_pkg::UNLOCK_ADDR1 :
                         (step == 2'h1) ? flash_ctl_pkg::UNLOCK_ADDR2 :
                         flash_ctl_pkg::UNLOCK_ADDR1;
  wire [15:0] seq_data = (step == 2'h0) ? flash_ctl_pkg::UNLOCK_DATA1 :
                         (step == 2'h1) ? flash_ctl_pkg::UNLOCK_DATA2 :
                         flash_ctl_pkg::ID_CMD_DATA;
  // reset command: address is don't care, data is the reset word
  wire [15:0] out_data = is_id_enter ? seq_data :
                         (cur.op == flash_ctl_pkg::OP_RESET_CMD) ?
                         flash_ctl_pkg::RESET_CMD_DATA : cur.data;
  wire [18:0] out_addr = is_id_enter ? seq_addr : cur.addr;
  wire cnt_done = cnt == 5'h00;
  // lockout: no request taken while supply is low, so no write starts
  wire take = (state == ST_IDLE) && req_valid_in && sup_sync;
  wire timeout_bit = dq_sync[5];
  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (take) next_state = ST_SETUP;
      ST_SETUP: if (cnt_done) next_state = ST_STROBE;
      ST_STROBE: if (cnt_done) next_state = ST_HOLD;
      ST_HOLD: if (cnt_done) next_state = last_step ? ST_DONE : ST_NEXT;
      ST_NEXT: next_state = ST_SETUP;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
      sup_meta <= 1'b0;
      sup_sync <= 1'b0;
    end else begin
      dq_meta <= flash_dq_in;
      dq_sync <= dq_meta;
      sup_meta <= supply_ok_in;
      sup_sync <= sup_meta;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur <= '0;
      step <= 2'h0;
    end else if (take) begin
      cur <= req_in;
      step <= 2'h0;
    end else if (state == ST_NEXT) begin
      step <= step + 2'h1;
    end
  end

  // one counter serves setup, strobe and hold phases
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 5'h00;
    end else if ((state == ST_IDLE) || (state == ST_NEXT)) begin
      cnt <= flash_ctl_pkg::SETUP_CNT;
    end else if ((state == ST_SETUP) && cnt_done) begin
      cnt <= flash_ctl_pkg::STROBE_CNT;
    end else if ((state == ST_STROBE) && cnt_done) begin
      cnt <= flash_ctl_pkg::SETUP_CNT;
    end else if (!cnt_done) begin
      cnt <= cnt - 5'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  wire in_cycle = (state != ST_IDLE) && (state != ST_DONE);
  wire drive_dq = !is_read && in_cycle;
  wire hv_read = (cur.op == flash_ctl_pkg::OP_ID_READ_HV) && in_cycle;
  wire unlock_hv = cur.op == flash_ctl_pkg::OP_UNPROTECT;
  wire next_oe_n = !is_read;
  wire next_we_n = is_read || unlock_hv;
  // the first three hold cycles see data sampled while output-enable was low;
  // the last hold cycle sees a released bus and must not feed any flag
  wire capture = (state == ST_HOLD) && is_read && (cnt == flash_ctl_pkg::SETUP_CNT);
  wire take_reset = take && (req_in.op == flash_ctl_pkg::OP_RESET_CMD);
  wire take_unprotect = take && (req_in.op == flash_ctl_pkg::OP_UNPROTECT);

  //////////////////////////////////////////////////////////////////////////////
  // strobes held inactive at reset so power-up shows no write pattern
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strobe_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else if (state == ST_STROBE) begin
      strobe_out.ce_n <= 1'b0;
      // write only with output-enable high
      strobe_out.oe_n <= next_oe_n;
      strobe_out.we_n <= next_we_n;
    end else begin
      // data held until after we rises
      strobe_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flash_addr_out <= 19'h00000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_out <= 1'b0;
    end else begin
      // address stable before chip-select and write fall
      if (state == ST_SETUP) flash_addr_out <= out_addr;
      if (state == ST_SETUP) flash_dq_out <= out_data;
      flash_dq_oe_out <= drive_dq;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_nine_hv_out <= 1'b0;
      reset_pin_hv_out <= 1'b0;
    end else begin
      // high voltage on address nine held across whole read
      addr_nine_hv_out <= hv_read;
      // temporary unprotect is a level; the next taken request other than an unprotect drops it
      if (take) reset_pin_hv_out <= take_unprotect;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ready_out <= 1'b0;
      rdata_out <= 16'h0000;
      rdata_valid_out <= 1'b0;
    end else begin
      ready_out <= (next_state == ST_IDLE) && sup_sync;
      rdata_valid_out <= capture;
      if (capture) rdata_out <= dq_sync;
    end
  end

  // sticky timeout seen; set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timeout_seen_out <= 1'b0;
    end else if (capture && timeout_bit) begin
      timeout_seen_out <= 1'b1;
    end else if (take_reset) begin
      timeout_seen_out <= 1'b0;
    end
  end

endmodule

// ===== tb/flash_host_chk.sv
// Purpose: port checks for the flash host controller
// Assumes: one clock, strobes active low
// Notes: bound to every controller instance
`timescale 1ns/1ps
module flash_host_chk (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic ready_out,
  input wire logic rdata_valid_out,
  input wire logic [18:0] flash_addr_out,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe_out,
  input wire flash_ctl_pkg::strobe_type strobe_out,
  input wire logic supply_ok_in
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  wr_rd_excl_a: assert property (strobe_out.we_n || strobe_out.oe_n)
    else $error("write and read strobes low together");
  we_with_ce_a: assert property (!strobe_out.we_n |-> !strobe_out.ce_n)
    else $error("write strobe without chip select");
  we_width_a: assert property ($fell(strobe_out.we_n) |-> ##10 !strobe_out.we_n ##1 strobe_out.we_n)
    else $error("write strobe width wrong");
  addr_steady_a: assert property (!strobe_out.ce_n |-> $stable(flash_addr_out))
    else $error("address moved under chip select");
  data_steady_a: assert property (!strobe_out.we_n |-> flash_dq_oe_out && $stable(flash_dq_out))
    else $error("write data not held");
  read_float_a: assert property (!strobe_out.oe_n |-> !flash_dq_oe_out)
    else $error("data driven during read");
  supply_lock_a: assert property (!supply_ok_in [*3] |=> !ready_out)
    else $error("ready while supply low");
  idle_strobes_a: assert property (ready_out |-> strobe_out == 3'h7)
    else $error("strobes active while idle");
  cover property ($fell(strobe_out.we_n));
  cover property (rdata_valid_out);
  cover property (!supply_ok_in ##1 !ready_out);
endmodule
bind flash_host_ctl flash_host_chk flash_host_chk_inst (.*);

// ===== tb/flash_dev_model.sv
// Purpose: behavioural flash device for the controller bench
// Assumes: array word reads as address xor 5A5A
// Notes: no embedded program or erase; id codes are arbitrary
`timescale 1ns/1ps
module flash_dev_model (
  input wire logic [18:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire flash_ctl_pkg::strobe_type strobe_in,
  input wire logic addr_nine_hv_in,
  output logic [15:0] dq_out
);
  localparam logic [15:0] MAKER = 16'h00C3; // arbitrary value
  localparam logic [15:0] DEV = 16'h00B4; // arbitrary value
  logic [1:0] step = 2'h0; // read array at power-up
  logic id_mode = 1'b0;
  logic [18:0] wa = 19'h00000;
  logic [15:0] last = 16'h0000;
  wire wr = !strobe_in.ce_n && !strobe_in.we_n && strobe_in.oe_n;
  wire rd = !strobe_in.ce_n && !strobe_in.oe_n;
  wire idv = id_mode || addr_nine_hv_in;
  // sectors never protected here
  // no program or erase, so no rejected or suspended reads to show
  wire [15:0] val = !idv ? addr_in[15:0] ^ 16'h5A5A : addr_in[1:0] == 2'h0 ? MAKER :
    addr_in[1:0] == 2'h1 ? DEV : 16'h0000;
  // released bus shows inverse so a late sample cannot pass
  assign dq_out = rd ? val : ~last;
  always @(negedge rd) last <= val;
  always @(posedge wr) wa <= addr_in;
  always @(negedge wr) begin
    if (dq_in == flash_ctl_pkg::RESET_CMD_DATA) begin
      step <= 2'h0;
      id_mode <= 1'b0;
    end else if (step == 2'h0) begin
      step <= {1'b0, wa == flash_ctl_pkg::UNLOCK_ADDR1 && dq_in == flash_ctl_pkg::UNLOCK_DATA1};
    end else if (step == 2'h1) begin
      step <= {wa == flash_ctl_pkg::UNLOCK_ADDR2 && dq_in == flash_ctl_pkg::UNLOCK_DATA2, 1'b0};
    end else begin
      step <= 2'h0;
      id_mode <= wa == flash_ctl_pkg::UNLOCK_ADDR1 && dq_in == flash_ctl_pkg::ID_CMD_DATA;
    end
  end
endmodule

// ===== tb/test_flash_host_ctl.sv
// Purpose: directed bench for the flash host controller
// Assumes: inputs change 1 ns after the rising edge
// Notes: array data follows the model's address pattern
`timescale 1ns/1ps
module test_flash_host_ctl;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic supply_ok_in = 1'b1;
  flash_ctl_pkg::req_type req_in = 38'h0;
  logic ready_out, rdata_valid_out, flash_dq_oe_out, addr_nine_hv_out, reset_pin_hv_out;
  logic timeout_seen_out;
  logic [15:0] rdata_out, flash_dq_out, flash_dq_in;
  logic [18:0] flash_addr_out;
  flash_ctl_pkg::strobe_type strobe_out;
  int fails = 0;
  int checks_done = 0;
  int pulses = 0;
  flash_host_ctl flash_host_ctl_inst (.sys_clk_in, .nrst_in, .req_in, .req_valid_in, .ready_out,
    .rdata_out, .rdata_valid_out, .flash_addr_out, .flash_dq_out, .flash_dq_oe_out,
    .flash_dq_in, .strobe_out, .addr_nine_hv_out, .reset_pin_hv_out, .timeout_seen_out,
    .supply_ok_in);
  flash_dev_model flash_dev_model_inst (.addr_in(flash_addr_out), .dq_in(flash_dq_out),
    .strobe_in(strobe_out), .addr_nine_hv_in(addr_nine_hv_out), .dq_out(flash_dq_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("mismatches %0d checks %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_out !== 1'b1) begin
      @(posedge sys_clk_in) #1;
      if (rdata_valid_out === 1'b1) pulses++;
      n++;
      if (n > 100) begin
        fails++;
        complete_run();
      end
    end
  endtask
  task automatic op(input flash_ctl_pkg::op_type o, input logic [18:0] a);
    wait_ready();
    req_in = {o, a, 16'h0000};
    req_valid_in = 1'b1;
    pulses = 0;
    @(posedge sys_clk_in) #1;
    req_valid_in = 1'b0;
    @(posedge sys_clk_in) #1;
    wait_ready();
  endtask
  task automatic wr(input logic [18:0] a, input logic [15:0] d);
    wait_ready();
    req_in = {flash_ctl_pkg::OP_WRITE, a, d};
    req_valid_in = 1'b1;
    @(posedge sys_clk_in) #1;
    req_valid_in = 1'b0;
    @(posedge sys_clk_in) #1;
  endtask
  task automatic rd(input flash_ctl_pkg::op_type o, input logic [18:0] a, input logic [15:0] e);
    op(o, a);
    chk(rdata_out, e);
    chk(16'(pulses), 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial forever #2 sys_clk_in = ~sys_clk_in;
  initial begin
    repeat (10) @(posedge sys_clk_in);
    #1 nrst_in = 1'b1;
    rd(flash_ctl_pkg::OP_READ, 19'h01234, 16'h486E);
    op(flash_ctl_pkg::OP_ID_ENTER, 19'h00000);
    rd(flash_ctl_pkg::OP_READ, flash_ctl_pkg::ID_MAKER_OFS, 16'h00C3);
    rd(flash_ctl_pkg::OP_READ, flash_ctl_pkg::ID_DEVICE_OFS, 16'h00B4);
    rd(flash_ctl_pkg::OP_READ, 19'h05002, 16'h0000);
    rd(flash_ctl_pkg::OP_READ, 19'h7F000, 16'h00C3);
    op(flash_ctl_pkg::OP_RESET_CMD, 19'h3ABCD);
    rd(flash_ctl_pkg::OP_READ, 19'h00000, 16'h5A5A);
    chk({15'h0, timeout_seen_out}, 16'h0000);
    wr(flash_ctl_pkg::UNLOCK_ADDR1, flash_ctl_pkg::UNLOCK_DATA1);
    wr(19'h00123, flash_ctl_pkg::UNLOCK_DATA2);
    wr(flash_ctl_pkg::UNLOCK_ADDR1, flash_ctl_pkg::ID_CMD_DATA);
    rd(flash_ctl_pkg::OP_READ, 19'h00000, 16'h5A5A);
    wr(flash_ctl_pkg::UNLOCK_ADDR1, flash_ctl_pkg::UNLOCK_DATA1);
    wr(flash_ctl_pkg::UNLOCK_ADDR2, flash_ctl_pkg::UNLOCK_DATA2);
    op(flash_ctl_pkg::OP_RESET_CMD, 19'h00000);
    wr(flash_ctl_pkg::UNLOCK_ADDR1, flash_ctl_pkg::ID_CMD_DATA);
    rd(flash_ctl_pkg::OP_READ, 19'h00001, 16'h5A5B);
    rd(flash_ctl_pkg::OP_ID_READ_HV, 19'h00000, 16'h00C3);
    rd(flash_ctl_pkg::OP_ID_READ_HV, 19'h00001, 16'h00B4);
    rd(flash_ctl_pkg::OP_ID_READ_HV, 19'h03002, 16'h0000);
    op(flash_ctl_pkg::OP_UNPROTECT, 19'h00000);
    chk({15'h0, reset_pin_hv_out}, 16'h0001);
    rd(flash_ctl_pkg::OP_READ, 19'h00020, 16'h5A7A);
    chk({15'h0, reset_pin_hv_out}, 16'h0000);
    chk({15'h0, timeout_seen_out}, 16'h0001);
    op(flash_ctl_pkg::OP_RESET_CMD, 19'h00000);
    chk({15'h0, timeout_seen_out}, 16'h0000);
    supply_ok_in = 1'b0;
    repeat (4) @(posedge sys_clk_in) #1;
    req_in = {flash_ctl_pkg::OP_READ, 19'h00000, 16'h0000};
    req_valid_in = 1'b1;
    repeat (20) begin
      @(posedge sys_clk_in) #1;
      chk({14'h0, ready_out, strobe_out.ce_n}, 16'h0001);
    end
    req_valid_in = 1'b0;
    supply_ok_in = 1'b1;
    rd(flash_ctl_pkg::OP_READ, 19'h00002, 16'h5A58);
    complete_run();
  end
endmodule
